// ---- rtl/timer16_pkg.sv ----
// constants of the 16-bit timer compare and waveform generator
package timer16_pkg;

  // ---------------------------------------------------------------
  // waveform modes
  // ---------------------------------------------------------------
  localparam logic [3:0] MODE_NORMAL   = 4'h0;
  localparam logic [3:0] MODE_CTC_A    = 4'h4;
  localparam logic [3:0] MODE_FAST_8   = 4'h5;
  localparam logic [3:0] MODE_FAST_9   = 4'h6;
  localparam logic [3:0] MODE_FAST_10  = 4'h7;
  localparam logic [3:0] MODE_CTC_CAP  = 4'hC;
  localparam logic [3:0] MODE_FAST_CAP = 4'hE;
  localparam logic [3:0] MODE_FAST_A   = 4'hF;

  // ---------------------------------------------------------------
  // compare output modes (2 and 3 mean non-inverted/inverted in pwm)
  // ---------------------------------------------------------------
  localparam logic [1:0] COM_NONE   = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR  = 2'h2;
  localparam logic [1:0] COM_SET    = 2'h3;

  // ---------------------------------------------------------------
  // counter values and reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] COUNT_BOTTOM = 16'h0000;
  localparam logic [15:0] COUNT_MAX    = 16'hFFFF;
  localparam logic [15:0] TOP_8BIT     = 16'h00FF;
  localparam logic [15:0] TOP_9BIT     = 16'h01FF;
  localparam logic [15:0] TOP_10BIT    = 16'h03FF;
  localparam logic [15:0] COMPARE_RST  = 16'h0000;
  localparam logic        LATCH_RST    = 1'b0;
  localparam logic        FLAG_RST     = 1'b0;

endpackage

// ---- rtl/timer16_compare_waveform_gen.sv ----
// counter, compare units and waveform generator of a 16-bit timer
`timescale 1ns/10ps
module timer16_compare_waveform_gen
  import timer16_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // timer control
  input  wire logic        tickEn,
  input  wire logic [3:0]  waveformMode,
  input  wire logic [1:0]  compareOutputModeA,
  input  wire logic [1:0]  compareOutputModeB,
  input  wire logic        forceCompareStrobeA,
  input  wire logic        forceCompareStrobeB,
  // register writes
  input  wire logic        compareValueAWr,
  input  wire logic [15:0] compareValueAData,
  input  wire logic        compareValueBWr,
  input  wire logic [15:0] compareValueBData,
  input  wire logic        counterWr,
  input  wire logic [15:0] counterData,
  input  wire logic [15:0] captureRegister,
  // flag acknowledges
  input  wire logic        overflowAck,
  input  wire logic        compareAckA,
  input  wire logic        compareAckB,
  input  wire logic        captureAck,
  // port pins
  input  wire logic        pinDirectionBitA,
  input  wire logic        pinDirectionBitB,
  input  wire logic        portOutA,
  input  wire logic        portOutB,
  // status
  output logic      [15:0] counterValue,
  output logic      [15:0] compareValueA,
  output logic      [15:0] compareValueB,
  output logic             overflowFlag,
  output logic             compareFlagA,
  output logic             compareFlagB,
  output logic             captureFlag,
  output logic             compareOutputLatchA,
  output logic             compareOutputLatchB,
  output logic             pinOutA,
  output logic             pinOutB,
  output logic             pinOeNA,
  output logic             pinOeNB
);

  // ---------------------------------------------------------------
  // mode decoding
  // ---------------------------------------------------------------
  function automatic logic isFastPwm(input logic [3:0] m);
    return m == MODE_FAST_8 || m == MODE_FAST_9 || m == MODE_FAST_10 ||
           m == MODE_FAST_CAP || m == MODE_FAST_A;
  endfunction

  function automatic logic usesCapTop(input logic [3:0] m);
    return m == MODE_CTC_CAP || m == MODE_FAST_CAP;
  endfunction

  function automatic logic [15:0] topOf(input logic [3:0] m,
                                        input logic [15:0] cmpA,
                                        input logic [15:0] cap);
    unique case (m)
      MODE_FAST_8:                 return TOP_8BIT;
      MODE_FAST_9:                 return TOP_9BIT;
      MODE_FAST_10:                return TOP_10BIT;
      MODE_CTC_CAP, MODE_FAST_CAP: return cap;
      MODE_CTC_A, MODE_FAST_A:     return cmpA;
      default:                     return COUNT_MAX;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // counter
  // ---------------------------------------------------------------
  logic            pwm;
  logic            clearMode;
  logic            blockMatch;
  logic            next_blockMatch;
  logic            atTop;
  logic            topEvent;
  logic            overflowEvent;
  logic     [15:0] next_counterValue;
  logic     [1:0]  match;
  logic     [1:0][15:0] cmpActive;

  // top from captureRegister, or compare A in MODE_CTC_A, is compared live, so a top
  // written below the count is missed until the counter wraps through MAX
  always_comb
  begin
    pwm       = isFastPwm(waveformMode);
    clearMode = pwm || waveformMode == MODE_CTC_A ||
                waveformMode == MODE_CTC_CAP;
    atTop     = clearMode && !blockMatch &&
                counterValue == topOf(waveformMode, cmpActive[0],
                                      captureRegister);
    topEvent  = tickEn && !counterWr && atTop;
    next_counterValue = counterValue;
    next_blockMatch   = blockMatch;
    if (counterWr)
    begin
      next_counterValue = counterData;
      next_blockMatch   = 1'b1;
    end
    else if (tickEn)
    begin
      next_blockMatch = 1'b0;
      if (atTop)
        next_counterValue = COUNT_BOTTOM;
      else
        next_counterValue = counterValue + 16'h0001;
    end
    overflowEvent = tickEn && !counterWr &&
                    (pwm ? atTop : counterValue == COUNT_MAX);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      counterValue <= COUNT_BOTTOM;
      blockMatch   <= 1'b0;
    end
    else
    begin
      counterValue <= next_counterValue;
      blockMatch   <= next_blockMatch;
    end
  end

  // ---------------------------------------------------------------
  // flags (a set in the acknowledge cycle wins)
  // ---------------------------------------------------------------
  logic next_overflowFlag;
  logic next_captureFlag;
  logic next_compareFlagA;
  logic next_compareFlagB;

  always_comb
  begin
    next_overflowFlag = overflowEvent ||
                        (overflowFlag && !overflowAck);
    next_captureFlag  = (topEvent && usesCapTop(waveformMode)) ||
                        (captureFlag && !captureAck);
    next_compareFlagA = match[0] || (compareFlagA && !compareAckA);
    next_compareFlagB = match[1] || (compareFlagB && !compareAckB);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      overflowFlag <= FLAG_RST;
      captureFlag  <= FLAG_RST;
      compareFlagA <= FLAG_RST;
      compareFlagB <= FLAG_RST;
    end
    else
    begin
      overflowFlag <= next_overflowFlag;
      captureFlag  <= next_captureFlag;
      compareFlagA <= next_compareFlagA;
      compareFlagB <= next_compareFlagB;
    end
  end

  // ---------------------------------------------------------------
  // compare channels
  // ---------------------------------------------------------------
  logic [1:0][1:0]  comSel;
  logic [1:0]       forceReq;
  logic [1:0]       latch;
  logic [1:0]       valWr;
  logic [1:0][15:0] valData;
  logic [1:0]       portOut;
  logic [1:0]       pinOut;
  assign comSel   = {compareOutputModeB, compareOutputModeA};
  assign forceReq = {forceCompareStrobeB, forceCompareStrobeA};
  assign valWr    = {compareValueBWr, compareValueAWr};
  assign valData  = {compareValueBData, compareValueAData};
  assign portOut  = {portOutB, portOutA};
  generate
    for (genvar i = 0; i < 2; i++)
    begin : g_chan
      logic [15:0] cmpBuf;
      logic [15:0] next_cmpBuf;
      logic [15:0] next_cmpActive;
      logic        next_latch;
      assign match[i]   = tickEn && !counterWr && !blockMatch &&
                          counterValue == cmpActive[i];
      always_comb
      begin
        next_cmpBuf    = cmpBuf;
        next_cmpActive = cmpActive[i];
        if (valWr[i])
        begin
          next_cmpBuf = valData[i];
          if (!pwm)
            next_cmpActive = valData[i];
        end
        if (pwm && topEvent)
          next_cmpActive = cmpBuf;
        // unchanged when the output mode is zero
        next_latch = latch[i];
        if (pwm)
        begin
          // code bit 0 is the level at top; a match drives the opposite
          if (topEvent && comSel[i][1])
            next_latch = comSel[i][0];
          // match after top so compare == top holds a constant level
          if (match[i] && comSel[i][1])
            next_latch = !comSel[i][0];
          if (match[i] && comSel[i] == COM_TOGGLE && i == 0 &&
              waveformMode == MODE_FAST_A)
            next_latch = !latch[i];
        end
        else if (match[i] || forceReq[i])
        begin
          if (comSel[i] == COM_TOGGLE)
            next_latch = !latch[i];
          if (comSel[i][1])
            next_latch = comSel[i][0];
        end
      end
      always_ff @(posedge clk)
      begin
        if (rst)
        begin
          cmpBuf       <= COMPARE_RST;
          cmpActive[i] <= COMPARE_RST;
          latch[i]     <= LATCH_RST;
        end
        else
        begin
          cmpBuf       <= next_cmpBuf;
          cmpActive[i] <= next_cmpActive;
          latch[i]     <= next_latch;
        end
      end
      // override only the value; direction stays with the port
      assign pinOut[i] = (comSel[i] != COM_NONE) ? latch[i]
                                                 : portOut[i];
    end
  endgenerate
  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign compareValueA       = cmpActive[0];
  assign compareValueB       = cmpActive[1];
  assign compareOutputLatchA = latch[0];
  assign compareOutputLatchB = latch[1];
  assign pinOutA             = pinOut[0];
  assign pinOutB             = pinOut[1];
  assign pinOeNA             = !pinDirectionBitA;
  assign pinOeNB             = !pinDirectionBitB;
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  AST_RESET_LATCH: assert property (@(posedge clk)
    disable iff (1'b0)
    rst |=> !compareOutputLatchA && !compareOutputLatchB)
    else $error("latch not cleared by reset");
  AST_PIN_OVERRIDE: assert property (
    compareOutputModeA != COM_NONE |-> pinOutA == compareOutputLatchA)
    else $error("pin not taken over by latch");
  AST_PIN_DIR: assert property (
    pinOeNB == !pinDirectionBitB && pinOeNA == !pinDirectionBitA)
    else $error("pin enable not following direction bit");
  AST_COM_ZERO: assert property (
    compareOutputModeB == COM_NONE |=> $stable(compareOutputLatchB))
    else $error("latch moved with output mode zero");
  AST_FORCE: assert property (
    !pwm && forceCompareStrobeA && compareOutputModeA == COM_TOGGLE
    && !compareFlagA && !match[0] && !compareAckA
    |=> compareOutputLatchA != $past(compareOutputLatchA) && !compareFlagA)
    else $error("force did not toggle or set a flag");
  AST_NORMAL_WRAP: assert property (
    tickEn && !counterWr && waveformMode == MODE_NORMAL
    && counterValue == COUNT_MAX |=> counterValue == COUNT_BOTTOM
    && overflowFlag)
    else $error("normal mode wrap or overflow wrong");
  AST_CTC_CLEAR: assert property (
    tickEn && !counterWr && !blockMatch && waveformMode == MODE_CTC_A
    && counterValue == compareValueA |=> counterValue == COUNT_BOTTOM
    && compareFlagA)
    else $error("clear on compare A failed");
  AST_FAST_TOP: assert property (
    pwm && topEvent |=> counterValue == COUNT_BOTTOM && overflowFlag
    && compareValueA == $past(g_chan[0].cmpBuf))
    else $error("fast pwm top handling wrong");
  AST_NO_TICK: assert property (
    !tickEn && !counterWr && !forceCompareStrobeA
    |=> $stable(counterValue) && $stable(compareOutputLatchA))
    else $error("state moved without a tick");
  AST_OVF_ACK: assert property (
    overflowAck && !overflowEvent |=> !overflowFlag)
    else $error("overflow acknowledge did not clear");
  AST_PWM_NONINV: assert property (
    pwm && match[0] && compareOutputModeA == COM_CLEAR
    |=> compareOutputLatchA ##1 (compareOutputLatchA || $past(topEvent)))
    else $error("non-inverted pwm not set on match");
  COV_NORMAL_WRAP: cover property (
    waveformMode == MODE_NORMAL && overflowEvent);
  COV_CTC_TOGGLE: cover property (
    waveformMode == MODE_CTC_A && match[0]
    && compareOutputModeA == COM_TOGGLE);
  COV_FAST_TOP: cover property (
    waveformMode == MODE_FAST_CAP && topEvent);
  COV_FORCE: cover property (!pwm && forceCompareStrobeB);

endmodule // timer16_compare_waveform_gen

// ---- verif/pin_load_model.sv ----
// external load on one timer output pin
`timescale 1ns/10ps
module pin_load_model #(
  parameter logic PULL_LEVEL = 1'b0
) (
  // drive from the device
  input  wire logic pinOut,
  input  wire logic pinOeN,
  // level seen on the board
  output logic      padLevel
);
  // an undriven pad sits at the board pull, never at the last driven value
  assign padLevel = pinOeN ? PULL_LEVEL : pinOut;
endmodule // pin_load_model

// ---- verif/timer16_compare_waveform_gen_test.sv ----
// self-checking bench of the timer compare and waveform generator
`timescale 1ns/10ps
`define CHECK(what, exp, got) \
  begin \
    testsRun++; \
    if ((got) !== (exp)) \
    begin \
      nFail++; \
      $display("[FAIL] %s expected %h seen %h", what, exp, got); \
    end \
  end
module timer16_compare_waveform_gen_test
  import timer16_pkg::*;
;
  // ------------------------------------------------------------
  // stimulus and observed signals
  // ------------------------------------------------------------
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        tickEn = 1'b0;
  logic [3:0]  waveformMode = 4'h0;
  logic [1:0]  compareOutputModeA = 2'h0;
  logic [1:0]  compareOutputModeB = 2'h0;
  logic [8:0]  strobe = 9'h000;
  logic [15:0] wrData = 16'h0000;
  logic [15:0] captureRegister = 16'h0000;
  logic        pinDirectionBitA = 1'b0;
  logic        pinDirectionBitB = 1'b0;
  logic        portOutA = 1'b0;
  logic        portOutB = 1'b0;
  wire logic   compareValueAWr, compareValueBWr, counterWr;
  wire logic   forceCompareStrobeA, forceCompareStrobeB;
  wire logic   overflowAck, compareAckA, compareAckB, captureAck;
  logic [15:0] counterValue, compareValueA, compareValueB;
  logic        overflowFlag, compareFlagA, compareFlagB, captureFlag;
  logic        compareOutputLatchA, compareOutputLatchB;
  logic        pinOutA, pinOutB, pinOeNA, pinOeNB, padA, padB;
  int          nFail = 0;
  int          testsRun = 0;
  int          cycles = 0;
  int          seed = 89910;

  // strobe bits: 0 wrA, 1 wrB, 2 counter, 3/4 force, 5..8 acks
  assign {captureAck, compareAckB, compareAckA, overflowAck,
          forceCompareStrobeB, forceCompareStrobeA, counterWr,
          compareValueBWr, compareValueAWr} = strobe;

  timer16_compare_waveform_gen u_dut (
    .clk, .rst, .tickEn, .waveformMode, .compareOutputModeA,
    .compareOutputModeB, .forceCompareStrobeA, .forceCompareStrobeB,
    .compareValueAWr, .compareValueAData(wrData), .compareValueBWr,
    .compareValueBData(wrData), .counterWr, .counterData(wrData),
    .captureRegister, .overflowAck, .compareAckA, .compareAckB,
    .captureAck, .pinDirectionBitA, .pinDirectionBitB, .portOutA,
    .portOutB, .counterValue, .compareValueA, .compareValueB,
    .overflowFlag, .compareFlagA, .compareFlagB, .captureFlag,
    .compareOutputLatchA, .compareOutputLatchB, .pinOutA, .pinOutB,
    .pinOeNA, .pinOeNB
  );
  pin_load_model u_loadA (
    .pinOut(pinOutA), .pinOeN(pinOeNA), .padLevel(padA)
  );
  pin_load_model u_loadB (
    .pinOut(pinOutB), .pinOeN(pinOeNB), .padLevel(padB)
  );

  always #25 clk = ~clk;

  // ------------------------------------------------------------
  // expectations and drivers
  // ------------------------------------------------------------
  function automatic logic expLatch(input logic [1:0] com, input logic old);
    case (com)
      COM_TOGGLE: return ~old;
      COM_CLEAR:  return 1'b0;
      COM_SET:    return 1'b1;
      default:    return old;
    endcase
  endfunction

  function automatic logic [15:0] fastTop(input logic [3:0] m,
                                          input logic [15:0] v);
    case (m)
      MODE_FAST_8:  return TOP_8BIT;
      MODE_FAST_9:  return TOP_9BIT;
      MODE_FAST_10: return TOP_10BIT;
      default:      return v;
    endcase
  endfunction

  task automatic step(input logic [8:0] m, input logic [15:0] d);
    @(posedge clk);
    strobe <= m;
    wrData <= d;
    @(posedge clk);
    strobe <= 9'h000;
    #1;
  endtask

  // ticks back to back; writes never share an edge with a tick
  task automatic ticks(input int n);
    repeat (n)
    begin
      @(posedge clk);
      tickEn <= 1'b1;
    end
    @(posedge clk);
    tickEn <= 1'b0;
    #1;
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", testsRun, nFail);
    if (nFail == 0 && testsRun > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      nFail++;
      end_of_test();
    end
  end

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial
  begin
    logic [1:0]  comList [5] = '{2'h3, 2'h1, 2'h1, 2'h2, 2'h0};
    logic [3:0]  modeList [5] = '{4'h5, 4'h6, 4'h7, 4'hE, 4'hF};
    logic [31:0] r;
    logic [15:0] cap, top, cmpB;
    logic        le, la;
    int          i, n;
    le = 1'b0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    #1;
    `CHECK("latchA", 1'b0, compareOutputLatchA);
    `CHECK("counter", 16'h0000, counterValue);
    for (i = 0; i < 5; i++)
    begin
      @(posedge clk);
      compareOutputModeA <= comList[i];
      compareOutputModeB <= comList[i];
      le = expLatch(comList[i], le);
      step(9'h018, 16'h0000);
      `CHECK("latchA", le, compareOutputLatchA);
      `CHECK("latchB", le, compareOutputLatchB);
      `CHECK("flagA", 1'b0, compareFlagA);
      `CHECK("counter", 16'h0000, counterValue);
    end
    @(posedge clk);
    compareOutputModeA <= COM_SET;
    step(9'h008, 16'h0000);
    `CHECK("padA", 1'b0, padA);
    `CHECK("oeNA", 1'b1, pinOeNA);
    @(posedge clk);
    pinDirectionBitA <= 1'b1;
    #1;
    `CHECK("padA", 1'b1, padA);
    la = 1'b1;
    repeat (4)
    begin
      r = $random(seed);
      @(posedge clk);
      compareOutputModeA <= COM_NONE;
      pinDirectionBitB <= 1'b1;
      portOutA <= r[0];
      portOutB <= r[1];
      #1;
      `CHECK("pinA", r[0], pinOutA);
      `CHECK("padB", r[1], padB);
    end
    step(9'h001, 16'hFFFF);
    step(9'h004, 16'hFFFE);
    ticks(2);
    `CHECK("counter", 16'h0000, counterValue);
    `CHECK("ovf", 1'b1, overflowFlag);
    `CHECK("latchA", la, compareOutputLatchA);
    ticks(1);
    repeat (5) @(posedge clk);
    #1;
    `CHECK("counter", 16'h0001, counterValue);
    step(9'h060, 16'h0000);
    `CHECK("ovf", 1'b0, overflowFlag);
    r = $random(seed);
    n = 3 + int'(r[3:0]);
    @(posedge clk);
    waveformMode <= MODE_CTC_A;
    compareOutputModeA <= COM_TOGGLE;
    step(9'h001, 16'(n));
    step(9'h004, 16'h0000);
    for (i = 0; i < 2; i++)
    begin
      ticks(n + 1);
      la = expLatch(COM_TOGGLE, la);
      `CHECK("counter", 16'h0000, counterValue);
      `CHECK("flagA", 1'b1, compareFlagA);
      `CHECK("latchA", la, compareOutputLatchA);
    end
    step(9'h060, 16'h0000);
    step(9'h004, 16'hFFFD);
    ticks(3);
    `CHECK("counter", 16'h0000, counterValue);
    `CHECK("flagA", 1'b0, compareFlagA);
    `CHECK("ovf", 1'b1, overflowFlag);
    @(posedge clk);
    waveformMode <= MODE_CTC_CAP;
    captureRegister <= 16'(n + 2);
    step(9'h104, 16'h0000);
    ticks(n + 3);
    `CHECK("counter", 16'h0000, counterValue);
    `CHECK("capF", 1'b1, captureFlag);
    for (i = 0; i < 5; i++)
    begin
      r = $random(seed);
      // register top stays well above the minimum of three
      cap = {10'h000, r[5:0]} | 16'h0010;
      top = fastTop(modeList[i], cap);
      cmpB = cap >> 1;
      @(posedge clk);
      waveformMode <= MODE_NORMAL;
      captureRegister <= cap;
      step(9'h001, cap);
      step(9'h002, cmpB);
      `CHECK("cmpB", cmpB, compareValueB);
      @(posedge clk);
      waveformMode <= modeList[i];
      compareOutputModeB <= r[8] ? COM_SET : COM_CLEAR;
      step(9'h1E4, top - 16'h0001);
      ticks(2);
      `CHECK("counter", 16'h0000, counterValue);
      `CHECK("ovf", 1'b1, overflowFlag);
      `CHECK("latchB", r[8], compareOutputLatchB);
      `CHECK("capF", modeList[i] == MODE_FAST_CAP, captureFlag);
      // compare A holds cap, so it matches whenever top equals cap
      `CHECK("flagA", top == cap, compareFlagA);
      ticks(int'(cmpB) + 1);
      `CHECK("counter", cmpB + 16'h0001, counterValue);
      `CHECK("latchB", ~r[8], compareOutputLatchB);
      `CHECK("flagB", 1'b1, compareFlagB);
    end
    step(9'h001, cap + 16'h0020);
    `CHECK("cmpA", cap, compareValueA);
    step(9'h004, cap - 16'h0001);
    ticks(2);
    `CHECK("cmpA", cap + 16'h0020, compareValueA);
    end_of_test();
  end
endmodule // timer16_compare_waveform_gen_test
